// >>> src/spi_port_consts.svh
// Purpose: named constants for the serial peripheral port
// Assumes: APB byte addresses, one register per aligned word
// Notes: bit positions follow the control and status layouts
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH
`define ADDR_CONTROL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_DATA 12'h008
`define CTRL_RESET 8'h14
`define CTRL_RATE_HI 7
`define CTRL_ENABLE 6
`define CTRL_SEL_DIS 5
`define CTRL_MASTER 4
`define CTRL_IDLE_LVL 3
`define CTRL_PHASE 2
`define CTRL_RATE_MID 1
`define CTRL_RATE_LO 0
`define STAT_DONE 7
`define STAT_WRITE_COLLISION_FLAG 6
`define STAT_MODE_FAULT_FLAG 4
`define RATE_EXT 3'h7
`define BIT_COUNT 4'h8
`endif

// >>> src/spi_port_pkg.sv
// Purpose: types shared by the serial peripheral port
// Assumes: nothing
// Notes: states of the master engine
package spi_port_pkg;
   typedef enum logic [1:0] {M_IDLE, M_LEAD, M_TRAIL} master_state_t;
   typedef logic [7:0] byte_t;
endpackage : spi_port_pkg

// >>> src/spi_master_slave_port.sv
// Purpose: serial peripheral port, master or slave, with APB registers
// Assumes: pin inputs asynchronous to CLOCK, peripheral clock is CLOCK
// Notes: two-way pins use active-low output enables
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_consts.svh"

module spi_master_slave_port
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // external baud tick, one clock wide, from another block on CLOCK
   input wire logic BAUD_TICK,
   // serial clock pin
   input wire logic SCK_IN,
   output logic SCK_OUT,
   output logic SCK_OE_N,
   // master out pin
   input wire logic MOSI_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE_N,
   // master in pin
   input wire logic MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE_N,
   // slave select, active low, input only
   input wire logic SS_N,
   // interrupt requests
   output logic TX_IRQ,
   output logic ERR_IRQ
);
   import spi_port_pkg::*;

   logic [7:0] control;
   spi_port_pkg::byte_t shifter;
   spi_port_pkg::byte_t rx_buf;
   logic done_flag, write_collision_flag_flag, mode_fault_flag_flag;
   logic done_armed, write_collision_flag_armed, mode_fault_flag_armed;
   logic [2:0] sync_ss, sync_sck;
   logic [1:0] sync_miso, sync_mosi;
   master_state_t mstate;
   logic [6:0] div_cnt;
   logic [3:0] bit_cnt;
   logic sample_bit;
   logic busy_slave;

   // pin synchronisers; stage 0 is read only by stage 1
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync_ss <= 3'h7;
         sync_sck <= 3'h0;
         sync_miso <= 2'h0;
         sync_mosi <= 2'h0;
      end
      else
      begin
         sync_ss <= {sync_ss[1:0], SS_N};
         sync_sck <= {sync_sck[1:0], SCK_IN};
         sync_miso <= {sync_miso[0], MISO_IN};
         sync_mosi <= {sync_mosi[0], MOSI_IN};
      end
   end

   wire ss_low = !sync_ss[1];
   // select rise closes a phase-zero frame; a low level alone opens one
   wire ss_rise = !sync_ss[2] && sync_ss[1];
   wire sck_s = sync_sck[1];
   wire sck_edge = sync_sck[2] != sync_sck[1];

   wire enable = control[`CTRL_ENABLE];
   wire is_master = control[`CTRL_MASTER];
   wire idle_lvl = control[`CTRL_IDLE_LVL];
   wire phase = control[`CTRL_PHASE];
   wire sel_dis = control[`CTRL_SEL_DIS];
   wire [2:0] rate = {control[`CTRL_RATE_HI], control[`CTRL_RATE_MID], control[`CTRL_RATE_LO]};

   // apb decode; zero wait states
   wire apb_acc = PSEL && PENABLE;
   wire wr = apb_acc && PWRITE;
   wire rd = apb_acc && !PWRITE;
   wire hit_ctrl = PADDR == `ADDR_CONTROL;
   wire hit_stat = PADDR == `ADDR_STATUS;
   wire hit_data = PADDR == `ADDR_DATA;
   wire mapped = hit_ctrl || hit_stat || hit_data;
   wire wr_ctrl = wr && hit_ctrl;
   wire wr_data = wr && hit_data;
   wire rd_stat = rd && hit_stat;
   wire rd_data = rd && hit_data;
   wire acc_data = apb_acc && hit_data;

   wire [7:0] status_val = {done_flag, write_collision_flag_flag, 1'b0, mode_fault_flag_flag, 4'h0};
   wire [7:0] rd_mux = hit_ctrl ? control : hit_stat ? status_val : hit_data ? rx_buf : 8'h00;

   // rate divider: half-period tick every 2^rate clocks, or per external tick
   wire [6:0] half_lim = 7'((8'h01 << rate) - 8'h01);
   wire tick = (rate == `RATE_EXT) ? BAUD_TICK : (div_cnt >= half_lim);

   wire m_busy = mstate != M_IDLE;
   // mode fault: master, select not disabled, select goes low
   wire mode_fault_flag_set = enable && is_master && !sel_dis && ss_low;

   // slave framing: phase clear ignores select disable
   wire slave_sel = (sel_dis && phase) ? 1'b1 : ss_low;
   wire slave_on = enable && !is_master && slave_sel;
   wire lead_edge = sck_edge && (sck_s != idle_lvl);
   wire trail_edge = sck_edge && (sck_s == idle_lvl);
   wire s_sample = phase ? trail_edge : lead_edge;
   wire s_shift = phase ? lead_edge : trail_edge;

   wire busy = m_busy || busy_slave;
   wire byte_end_m;
   wire byte_end_s = slave_on && s_sample && bit_cnt == `BIT_COUNT - 4'h1;
   assign byte_end_m = m_busy && tick && mstate == M_TRAIL && bit_cnt == `BIT_COUNT - 4'h1;
   wire byte_end = byte_end_m || byte_end_s;
   wire [7:0] rx_byte = {shifter[6:0], is_master ? sync_miso[1] : sync_mosi[1]};

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         control <= `CTRL_RESET;
         PRDATA <= 32'h0000_0000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         if (mode_fault_flag_set)
         begin
            control[`CTRL_ENABLE] <= 1'b0;
            control[`CTRL_MASTER] <= 1'b0;
         end
         else if (wr_ctrl)
            control <= PWDATA[7:0];
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !mapped;
         PRDATA <= (PSEL && !PENABLE && !PWRITE) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // sticky flags: the set wins over the clearing sequence
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         done_flag <= 1'b0;
         write_collision_flag_flag <= 1'b0;
         mode_fault_flag_flag <= 1'b0;
         done_armed <= 1'b0;
         write_collision_flag_armed <= 1'b0;
         mode_fault_flag_armed <= 1'b0;
      end
      else
      begin
         if (rd_stat)
            done_armed <= done_flag;
         if (rd_stat)
            mode_fault_flag_armed <= mode_fault_flag_flag;
         if (apb_acc && hit_stat)
            write_collision_flag_armed <= write_collision_flag_flag;
         if (byte_end)
            done_flag <= 1'b1;
         else if (rd_data && done_armed)
         begin
            done_flag <= 1'b0;
            done_armed <= 1'b0;
         end
         if (wr_data && busy)
            write_collision_flag_flag <= 1'b1;
         else if (acc_data && write_collision_flag_armed)
         begin
            write_collision_flag_flag <= 1'b0;
            write_collision_flag_armed <= 1'b0;
         end
         if (mode_fault_flag_set)
            mode_fault_flag_flag <= 1'b1;
         else if (wr_ctrl && mode_fault_flag_armed)
         begin
            mode_fault_flag_flag <= 1'b0;
            mode_fault_flag_armed <= 1'b0;
         end
      end
   end

   // receive buffer holds the first byte after the done flag was cleared
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         rx_buf <= 8'h00;
      else if (byte_end && !done_flag)
         rx_buf <= rx_byte;
   end

   // rate divider
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         div_cnt <= 7'h00;
      else if (!m_busy || tick)
         div_cnt <= 7'h00;
      else
         div_cnt <= div_cnt + 7'h01;
   end

   // shift engine, both roles; a collided write leaves the shifter alone except in the disable, fault and deselect branches, which load it
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mstate <= M_IDLE;
         shifter <= 8'h00;
         bit_cnt <= 4'h0;
         sample_bit <= 1'b0;
         busy_slave <= 1'b0;
         SCK_OUT <= 1'b0;
         MOSI_OUT <= 1'b0;
         MISO_OUT <= 1'b0;
      end
      else if (!enable || mode_fault_flag_set)
      begin
         mstate <= M_IDLE;
         bit_cnt <= 4'h0;
         busy_slave <= 1'b0;
         SCK_OUT <= idle_lvl;
         if (wr_data)
            shifter <= PWDATA[7:0];
      end
      else if (is_master)
      begin
         busy_slave <= 1'b0;
         case (mstate)
            M_IDLE:
            begin
               SCK_OUT <= idle_lvl;
               if (wr_data)
               begin
                  shifter <= PWDATA[7:0];
                  MOSI_OUT <= PWDATA[7];
                  bit_cnt <= 4'h0;
                  mstate <= M_LEAD;
               end
            end
            M_LEAD:
               if (tick)
               begin
                  SCK_OUT <= !idle_lvl;
                  if (phase)
                     MOSI_OUT <= shifter[7];
                  else
                     sample_bit <= sync_miso[1];
                  mstate <= M_TRAIL;
               end
            M_TRAIL:
               if (tick)
               begin
                  SCK_OUT <= idle_lvl;
                  shifter <= {shifter[6:0], phase ? sync_miso[1] : sample_bit};
                  bit_cnt <= bit_cnt + 4'h1;
                  if (!phase)
                     MOSI_OUT <= shifter[6];
                  mstate <= (bit_cnt == `BIT_COUNT - 4'h1) ? M_IDLE : M_LEAD;
               end
            default:
               mstate <= M_IDLE;
         endcase
      end
      else
      begin
         mstate <= M_IDLE;
         SCK_OUT <= idle_lvl;
         if (!slave_sel || (!phase && ss_rise))
         begin
            bit_cnt <= 4'h0;
            busy_slave <= 1'b0;
            if (wr_data)
               shifter <= PWDATA[7:0];
            MISO_OUT <= wr_data ? PWDATA[7] : shifter[7];
         end
         else if (s_sample)
         begin
            sample_bit <= sync_mosi[1];
            busy_slave <= bit_cnt != `BIT_COUNT - 4'h1;
            if (phase)
               shifter <= rx_byte;
            if (bit_cnt == `BIT_COUNT - 4'h1)
               bit_cnt <= 4'h0;
            else
               bit_cnt <= bit_cnt + 4'h1;
         end
         else if (s_shift)
         begin
            busy_slave <= 1'b1;
            if (phase)
               MISO_OUT <= shifter[7];
            else
            begin
               shifter <= {shifter[6:0], sample_bit};
               MISO_OUT <= shifter[6];
            end
         end
         else if (!busy_slave && wr_data)
         begin
            shifter <= PWDATA[7:0];
            MISO_OUT <= PWDATA[7];
         end
      end
   end

   // pin enables and interrupt requests, registered
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         SCK_OE_N <= 1'b1;
         MOSI_OE_N <= 1'b1;
         MISO_OE_N <= 1'b1;
         TX_IRQ <= 1'b0;
         ERR_IRQ <= 1'b0;
      end
      else
      begin
         SCK_OE_N <= !(enable && is_master && !mode_fault_flag_set);
         MOSI_OE_N <= !(enable && is_master && !mode_fault_flag_set);
         // selected slave, or any enabled slave with select disabled and phase set; otherwise the line is left free
         MISO_OE_N <= !(slave_on && !mode_fault_flag_set);
         TX_IRQ <= done_flag || byte_end;
         ERR_IRQ <= (mode_fault_flag_flag || mode_fault_flag_set) && !sel_dis;
      end
   end
endmodule : spi_master_slave_port
`default_nettype wire

// >>> testbench/spi_port_monitor.sv
// Purpose: port-level checker for the serial port
// Assumes: one clock domain, async active-low reset
// Notes: bound to the top module at the foot
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_consts.svh"
module spi_port_monitor
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // pins and requests
   input wire logic SCK_OUT,
   input wire logic SCK_OE_N,
   input wire logic MOSI_OE_N,
   input wire logic MISO_OE_N,
   input wire logic SS_N,
   input wire logic TX_IRQ,
   input wire logic ERR_IRQ
);
   wire take = PSEL && PENABLE && PREADY;
   wire rd_data = take && !PWRITE && PADDR == `ADDR_DATA;
   wire wr_ctrl = take && PWRITE && PADDR == `ADDR_CONTROL;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_bad_addr;
      PADDR > `ADDR_DATA || PADDR[1:0] != 2'h0;
   endsequence
   property p_ready;
      s_setup |=> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_slverr;
      s_setup ##0 s_bad_addr |=> PSLVERR && PREADY;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");
   property p_idle;
      $rose(TX_IRQ) && !SCK_OE_N |=> $stable(SCK_OUT) [*6];
   endproperty
   a_idle: assert property (p_idle) else $error("clock moved after byte");
   property p_err_off;
      $rose(ERR_IRQ) |-> ##1 (SCK_OE_N && MOSI_OE_N);
   endproperty
   a_err_off: assert property (p_err_off) else $error("unit on after fault");
   property p_err_cause;
      $rose(ERR_IRQ) |-> !$past(SS_N, 2);
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("fault without select");
   property p_done_clr;
      $fell(TX_IRQ) |-> $past(rd_data) || $past(rd_data, 2);
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("done fell alone");
   property p_err_clr;
      $fell(ERR_IRQ) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
   endproperty
   a_err_clr: assert property (p_err_clr) else $error("fault fell alone");
   property p_roles;
      !MISO_OE_N |-> SCK_OE_N && MOSI_OE_N;
   endproperty
   a_roles: assert property (p_roles) else $error("slave and master at once");
endmodule : spi_port_monitor
bind spi_master_slave_port spi_port_monitor u_mon
(
   .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SCK_OUT(SCK_OUT), .SCK_OE_N(SCK_OE_N), .MOSI_OE_N(MOSI_OE_N),
   .MISO_OE_N(MISO_OE_N), .SS_N(SS_N), .TX_IRQ(TX_IRQ), .ERR_IRQ(ERR_IRQ)
);
`default_nettype wire

// >>> testbench/spi_slave_model.sv
// Purpose: behavioural serial slave facing the port
// Assumes: sel_n frames every byte
// Notes: an undriven miso shows the inverse of the bit held at the latest shift edge, or of tx bit 7 if none since select fall
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model
(
   // link
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   output logic miso,
   // setup and data
   input wire logic clock_idle_level,
   input wire logic clock_sample_phase,
   input wire logic [7:0] tx,
   output logic [7:0] rx
);
   int n = 0;
   int k;
   logic last = 1'b0;
   always @(negedge sel_n)
   begin
      n = 0;
      last = ~tx[7];
   end
   always @(sck)
   begin
      if (!sel_n && ((sck != clock_idle_level) ^ clock_sample_phase))
         rx = {rx[6:0], mosi};
      else if (!sel_n)
      begin
         last = ~miso;
         n = n + 1;
      end
   end
   always_comb
   begin
      k = n - int'(clock_sample_phase);
      // phase zero shows bit 7 from select fall on
      miso = (!sel_n && k >= 0 && k < 8) ? tx[7 - k] : last;
   end
endmodule : spi_slave_model
`default_nettype wire

// >>> testbench/spi_master_slave_port_tb.sv
// Purpose: self-checking bench for the serial port
// Assumes: 20 MHz clock, async active-low reset
// Notes: random bytes from a fixed seed, slave model on the far side
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_consts.svh"
module spi_master_slave_port_tb;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, tick = 0;
   logic ss_n = 1, sel_n = 1, clock_idle_level = 0, clock_sample_phase = 0, err, sck_q = 0, mclk = 0, mmosi = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [7:0] stx = 0, srx, b, mrx, got;
   wire [31:0] prdata;
   wire pready, pslverr, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_o, miso_oe_n;
   wire tx_irq, err_irq;
   wire sck_in = sck_oe_n ? (clock_idle_level ^ mclk) : sck;
   wire mosi_in = mosi_oe_n ? mmosi : mosi;
   wire miso_in = miso_oe_n ? miso : miso_o;
   int n_mismatch = 0, checked = 0, edges = 0, span = 0, gap = 0;
   spi_master_slave_port u_dut
   (
      .CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BAUD_TICK(tick), .SCK_IN(sck_in), .SCK_OUT(sck),
      .SCK_OE_N(sck_oe_n), .MOSI_IN(mosi_in), .MOSI_OUT(mosi), .MOSI_OE_N(mosi_oe_n),
      .MISO_IN(miso_in), .MISO_OUT(miso_o), .MISO_OE_N(miso_oe_n), .SS_N(ss_n),
      .TX_IRQ(tx_irq), .ERR_IRQ(err_irq)
   );
   spi_slave_model u_slave
   (
      .sck(sck), .mosi(mosi), .sel_n(sel_n), .miso(miso),
      .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase), .tx(stx), .rx(srx)
   );
   always #25 clk = ~clk;
   always @(posedge clk)
   begin
      tick <= ($urandom_range(3) == 0);
      sck_q <= sck;
      gap <= (sck !== sck_q) ? 1 : gap + 1;
      if (sck !== sck_q)
      begin
         edges <= edges + 1;
         span <= gap;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      // only the watchdog ends a wait for the answer
      while (pready !== 1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
   endtask : apb
   // bench as phase-one master: shift on leading edge, sample on trailing
   task automatic sxfer(input logic [7:0] d);
      for (int j = 7; j >= 0; j--)
      begin
         repeat (8) @(posedge clk);
         mclk <= 1;
         mmosi <= d[j];
         repeat (8) @(posedge clk);
         mclk <= 0;
         got[j] = miso_o;
      end
   endtask : sxfer
   function automatic logic [31:0] ctl(input logic [2:0] r, input logic en, sd, ms);
      return {24'h0, r[2], en, sd, ms, clock_idle_level, clock_sample_phase, r[1:0]};
   endfunction : ctl
   task automatic xfer(input logic [7:0] d, input logic coll);
      int i;
      i = 0;
      repeat (3) @(posedge clk);
      stx = 8'($urandom);
      sel_n <= 0;
      edges = 0;
      apb(1, `ADDR_DATA, {24'h0, d});
      if (coll)
         apb(1, `ADDR_DATA, {24'h0, ~d});
      while (edges < 16 && i++ < 5000)
         @(posedge clk);
      repeat (4) @(posedge clk);
      chk(srx, d);
      sel_n <= 1;
   endtask : xfer
   initial
   begin
      rd = $urandom(32'h9D4C3C0E);
      repeat (4) @(posedge clk);
      rst_n <= 1;
      apb(0, `ADDR_CONTROL, 0);
      chk(rd, `CTRL_RESET);
      apb(0, 12'h00C, 0);
      chk(rd, 0);
      chk(err, 1);
      for (int k = 0; k < 8; k++)
      begin
         clock_idle_level = k[0];
         clock_sample_phase = k[1];
         apb(1, `ADDR_CONTROL, ctl(k[2:0], 0, 0, 1));
         apb(1, `ADDR_CONTROL, ctl(k[2:0], 1, 0, 1));
         b = 8'($urandom);
         xfer(b, 0);
         chk(sck, clock_idle_level);
         chk(edges, 16);
         chk(tx_irq, 1);
         if (k < 7)
            chk(span, 1 << k);
         apb(0, `ADDR_STATUS, 0);
         chk(rd, 32'h80);
         apb(0, `ADDR_DATA, 0);
         if (k > 1 && k < 7)
            chk(rd, stx);
         apb(0, `ADDR_STATUS, 0);
         chk(rd, 0);
      end
      apb(1, `ADDR_CONTROL, ctl(3, 1, 0, 1));
      xfer(b, 1);
      apb(0, `ADDR_STATUS, 0);
      chk(rd, 32'hC0);
      mrx = stx;
      xfer(~b, 0);
      apb(0, `ADDR_STATUS, 0);
      chk(rd, 32'h80);
      apb(0, `ADDR_DATA, 0);
      chk(rd, mrx);
      ss_n <= 0;
      repeat (10) @(posedge clk);
      chk(err_irq, 1);
      ss_n <= 1;
      apb(0, `ADDR_STATUS, 0);
      chk(rd, 32'h10);
      apb(0, `ADDR_CONTROL, 0);
      chk(rd, ctl(3, 0, 0, 0));
      apb(1, `ADDR_CONTROL, ctl(3, 1, 1, 1));
      apb(0, `ADDR_STATUS, 0);
      chk(rd, 0);
      ss_n <= 0;
      repeat (10) @(posedge clk);
      chk({err_irq, sck_oe_n}, 0);
      apb(1, `ADDR_CONTROL, ctl(3, 1, 0, 0));
      repeat (6) @(posedge clk);
      chk({sck_oe_n, miso_oe_n}, 2'b10);
      b = 8'($urandom);
      mrx = 8'($urandom);
      apb(1, `ADDR_DATA, {24'h0, b});
      sxfer(mrx);
      chk(got, b);
      repeat (4) @(posedge clk);
      apb(0, `ADDR_STATUS, 0);
      chk(rd, 32'h80);
      apb(0, `ADDR_DATA, 0);
      chk(rd, mrx);
      apb(1, `ADDR_CONTROL, ctl(3, 0, 0, 0));
      repeat (4) @(posedge clk);
      chk(miso_oe_n, 1);
      ss_n <= 1;
      apb(1, `ADDR_CONTROL, ctl(3, 1, 1, 0));
      repeat (6) @(posedge clk);
      chk(miso_oe_n, 0);
      apb(1, `ADDR_CONTROL, ctl(3, 0, 1, 0));
      clock_sample_phase = 0;
      apb(1, `ADDR_CONTROL, ctl(3, 0, 1, 0));
      apb(1, `ADDR_CONTROL, ctl(3, 1, 1, 0));
      repeat (6) @(posedge clk);
      chk(miso_oe_n, 1);
      give_verdict();
   end
   initial
   begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
endmodule : spi_master_slave_port_tb
`default_nettype wire
